// ==== logic/ext_master_auto_ack.sv ====
`timescale 1ns/1ns
`default_nettype none
module ext_master_auto_ack
    import ext_ack_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_cycle_begin_strobe_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic i_read_write,
    input wire logic [1:0] i_transfer_size,
    input wire logic i_default_space,
    input wire logic i_master_auto_ack_enable,
    input wire logic [WAIT_W-1:0] i_wait_count_field,
    output logic o_termination_ack_n,
    output logic o_termination_ack_oe,
    output logic o_addr_oe,
    output logic [ADDR_W-1:0] o_cap_addr,
    output logic o_cap_read_write,
    output logic [1:0] o_cap_transfer_size,
    output logic o_busy
);
    typedef struct packed {
        ack_state_e state;
        logic [ADDR_W-1:0] addr;
        logic rw;
        logic [1:0] size;
        logic [WAIT_W-1:0] wait_cnt;
        logic ack_n;
        logic ack_oe;
        logic busy; // registered so o_busy leaves a flop directly
        logic addr_oe; // stays low: the master owns the address pins
    } ack_s;

    ack_s cur;
    ack_s next_cur;

    // next-state logic; strobe only honoured from idle, so a glitch mid-cycle is ignored
    always_comb begin
        next_cur = cur;
        case (cur.state)
            ST_IDLE: begin
                next_cur.ack_oe = 1'b0;
                next_cur.ack_n = 1'b1;
                if (!i_cycle_begin_strobe_n) begin
                    next_cur.addr = i_addr; // R1
                    next_cur.rw = i_read_write; // R1
                    next_cur.size = i_transfer_size; // R1
                    next_cur.state = ST_DECODE; // R2
                end
            end
            ST_DECODE: begin
                // decode clock: only default space with enable gets a driven ack
                if (i_default_space && i_master_auto_ack_enable) begin
                    next_cur.wait_cnt = i_wait_count_field; // R3
                    next_cur.ack_oe = 1'b1; // R15
                    if (i_wait_count_field == WAIT_RESET) begin
                        next_cur.ack_n = 1'b0; // R4
                        next_cur.state = ST_ACK;
                    end else begin
                        next_cur.ack_n = 1'b1; // R5
                        next_cur.state = ST_WAIT;
                    end
                end else begin
                    next_cur.ack_oe = 1'b0; // R18
                    next_cur.state = ST_IDLE;
                end
            end
            ST_WAIT: begin
                // count down; the last wait clock launches the acknowledge
                next_cur.wait_cnt = cur.wait_cnt - WAIT_STEP;
                if (cur.wait_cnt == WAIT_LAST) begin
                    next_cur.ack_n = 1'b0; // R5
                    next_cur.state = ST_ACK;
                end
            end
            ST_ACK: begin
                next_cur.ack_n = 1'b1; // R6
                next_cur.state = ST_NEGATE;
            end
            ST_NEGATE: begin
                next_cur.ack_oe = 1'b0; // R6
                next_cur.state = ST_IDLE;
            end
            default: begin
                next_cur.state = ST_IDLE;
                next_cur.ack_oe = 1'b0;
                next_cur.ack_n = 1'b1;
            end
        endcase
        // address pins are never driven here, whatever the state
        next_cur.addr_oe = 1'b0; // R16
        // busy follows the next state so it comes out of a flop
        next_cur.busy = (next_cur.state != ST_IDLE);
    end

    // single register bank for all state
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            cur.state <= ST_IDLE;
            cur.addr <= ADDR_RESET;
            cur.rw <= RW_RESET;
            cur.size <= SIZE_RESET;
            cur.wait_cnt <= WAIT_RESET;
            cur.ack_n <= 1'b1;
            cur.ack_oe <= 1'b0;
            cur.busy <= 1'b0;
            cur.addr_oe <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    // every output is a field of the registered state
    assign o_termination_ack_n = cur.ack_n;
    assign o_termination_ack_oe = cur.ack_oe;
    assign o_addr_oe = cur.addr_oe;
    assign o_cap_addr = cur.addr;
    assign o_cap_read_write = cur.rw;
    assign o_cap_transfer_size = cur.size;
    assign o_busy = cur.busy;

    // address and direction taken at the strobe edge
    capture_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R1
        (cur.state == ST_IDLE && !i_cycle_begin_strobe_n) |=>
        (o_cap_addr == $past(i_addr) && o_cap_read_write == $past(i_read_write)))
        else $error("cycle fields not captured");

    // size taken with the address
    size_capture_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R1
        (cur.state == ST_IDLE && !i_cycle_begin_strobe_n) |=>
        (o_cap_transfer_size == $past(i_transfer_size)))
        else $error("cycle size not captured");

    // fields frozen while the cycle runs, so a stray strobe cannot clobber them
    cap_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R1
        o_busy |=> ($stable(o_cap_addr) && $stable(o_cap_read_write)))
        else $error("captured fields moved mid-cycle");

    // strobe edge is followed by the decode clock
    decode_clock_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R2
        (cur.state == ST_IDLE && !i_cycle_begin_strobe_n) |=> cur.state == ST_DECODE)
        else $error("no decode clock after strobe");

    // decode lasts exactly one clock
    decode_once_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R2
        (cur.state == ST_DECODE) |=> (cur.state != ST_DECODE))
        else $error("decode clock repeated");

    // programmed wait count is what lands in the counter
    wait_load_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R3
        (cur.state == ST_DECODE && i_default_space && i_master_auto_ack_enable) |=>
        (cur.wait_cnt == $past(i_wait_count_field)))
        else $error("wait count not loaded");

    // zero waits: acknowledge low two clocks after the strobe
    zero_wait_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R4
        (cur.state == ST_IDLE && !i_cycle_begin_strobe_n) ##1
        (i_default_space && i_master_auto_ack_enable && i_wait_count_field == 4'h0)
        |=> (!o_termination_ack_n && o_termination_ack_oe))
        else $error("zero-wait ack not at third edge");

    // acknowledge low only ever comes from the acknowledge state
    ack_state_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R4
        !o_termination_ack_n |-> (cur.state == ST_ACK))
        else $error("ack asserted outside ack state");

    // driving starts only out of the decode clock
    oe_origin_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R4
        $rose(o_termination_ack_oe) |-> ($past(cur.state) == ST_DECODE))
        else $error("ack driven without a decode clock");

    // nonzero waits: driven but negated first
    wait_negated_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R5
        (cur.state == ST_DECODE && i_default_space && i_master_auto_ack_enable &&
        i_wait_count_field != 4'h0) |=> (o_termination_ack_oe && o_termination_ack_n))
        else $error("ack not negated during wait");

    // counter holds the acknowledge negated while it runs
    wait_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R5
        (cur.state == ST_WAIT) |-> (o_termination_ack_oe && o_termination_ack_n))
        else $error("ack not held negated in wait");

    // last wait clock hands over to the acknowledge
    last_wait_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R5
        (cur.state == ST_WAIT && cur.wait_cnt == 4'h1) |=> !o_termination_ack_n)
        else $error("ack late after last wait");

    // two programmed waits give two negated clocks before the acknowledge
    wait_len_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R15
        (cur.state == ST_DECODE && i_default_space && i_master_auto_ack_enable &&
        i_wait_count_field == 4'h2) |=> o_termination_ack_n ##1 o_termination_ack_n
        ##1 !o_termination_ack_n)
        else $error("ack wait count wrong");

    // one wait clock consumed per edge, never skipped
    count_down_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R15
        (cur.state == ST_WAIT && cur.wait_cnt != 4'h1) |=>
        (cur.state == ST_WAIT && cur.wait_cnt == $past(cur.wait_cnt) - 4'h1))
        else $error("wait counter skipped");

    // default space with enable gets a driven pin in the clock after decode
    oe_start_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R15
        (cur.state == ST_DECODE && i_default_space && i_master_auto_ack_enable) |=>
        o_termination_ack_oe)
        else $error("ack not driven after decode");

    // acknowledge lasts one clock, then negated, then released
    ack_release_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R6
        (o_termination_ack_oe && !o_termination_ack_n) |=>
        (o_termination_ack_oe && o_termination_ack_n) ##1 !o_termination_ack_oe)
        else $error("ack not negated then released");

    // after negation the cycle is over and the pin is let go
    busy_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R6
        (cur.state == ST_NEGATE) |=> (!o_busy && !o_termination_ack_oe))
        else $error("cycle not closed after negate");

    // enable off: another agent has to terminate
    no_enable_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R18
        (cur.state == ST_DECODE && !i_master_auto_ack_enable) |=> !o_termination_ack_oe)
        else $error("ack driven with auto-ack off");

    // other spaces are left to their own terminator
    no_space_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R18
        (cur.state == ST_DECODE && !i_default_space) |=>
        (!o_termination_ack_oe && !o_busy))
        else $error("ack driven outside default space");

    // a released pin sits at its inactive level, no glitch on the next drive
    idle_level_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R18
        !o_termination_ack_oe |-> o_termination_ack_n)
        else $error("released ack not high");

    // address pins stay with the master for the whole cycle
    addr_quiet_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R16
        o_busy |-> !o_addr_oe)
        else $error("address driven in master cycle");
endmodule
`default_nettype wire

// ==== logic/ext_ack_pkg.sv ====
// Notes on behaviour
// [R1] capture address, direction and size at the edge after the cycle-begin strobe
// [R2] one extra decode clock before the wait counter starts
// [R3] during decode, if auto-ack enabled, load the programmed wait count
// [R4] wait count zero: acknowledge asserted at third edge, two clocks after strobe
// [R5] wait count nonzero: drive acknowledge negated first, assert after wait clocks
// [R6] negate acknowledge the clock after acknowledging, then release to high impedance
// [R7] master read: valid address, direction high, size, strobe in first clock
// [R8] master write: valid address, direction low, size, strobe in first clock
// [R9] master negates strobe in second clock and samples acknowledge
// [R10] on read, master captures data when acknowledge asserted, else waits; the bus master model takes no read data and records only the acknowledge edge
// [R11] master resamples acknowledge every edge, never ends cycle while negated; the bus master model gives up after edge 20 with acknowledge still negated
// [R12] on write, master drives write data in second clock
// [R13] master holds write data unchanged through inserted wait clocks
// [R14] after write acknowledged, master releases data bus next clock
// [R15] default memory cycles with auto-ack set acknowledge after wait-field clocks
// [R16] device never drives the address bus during default-memory master cycles
// [R17] master issues only naturally aligned transfers
// [R18] auto-ack clear: acknowledge left undriven for default-memory cycles
`default_nettype none
package ext_ack_pkg;
    localparam int ADDR_W = 28;
    localparam int WAIT_W = 4;
    localparam logic [WAIT_W-1:0] WAIT_RESET = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 28'h0000000;
    localparam logic [1:0] SIZE_RESET = 2'h0;
    localparam logic RW_RESET = 1'b1; // idle direction reads as a read
    localparam logic [WAIT_W-1:0] WAIT_LAST = 4'h1; // count value of the final wait clock
    localparam logic [WAIT_W-1:0] WAIT_STEP = 4'h1;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_DECODE = 5'b00010,
        ST_WAIT = 5'b00100,
        ST_ACK = 5'b01000,
        ST_NEGATE = 5'b10000
    } ack_state_e;
endpackage
`default_nettype wire

// ==== verification/ext_bus_master_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// external master: one single cycle per rising go
module ext_bus_master_model
    import ext_ack_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic i_rd,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [1:0] i_size,
    input wire logic i_ack_n,
    output logic o_strobe_n = 1'b1,
    output logic [ADDR_W-1:0] o_addr = '0,
    output logic o_rw = 1'b1,
    output logic [1:0] o_size = 2'h0,
    output logic [31:0] o_data = 32'h0,
    output logic o_data_oe = 1'b0,
    output logic o_done = 1'b0,
    output int o_edges = 0
);
    int n;
    // released data keeps changing so stale data never looks valid
    always @(posedge i_clk) if (!o_data_oe) o_data <= ~o_data;
    // bounded wait: gives up after 20 edges, the refusal case
    always @(posedge i_go) begin
        o_done = 1'b0;
        o_edges = 0;
        @(negedge i_clk);
        o_strobe_n <= 1'b0;
        o_addr <= i_addr;
        o_rw <= i_rd;
        o_size <= i_size;
        @(negedge i_clk);
        o_strobe_n <= 1'b1;
        o_data_oe <= !i_rd;
        o_data <= {4'hA, i_addr};
        for (n = 2; n < 21 && o_edges == 0; n++) begin
            @(posedge i_clk);
            if (i_ack_n === 1'b0) begin
                o_edges = n;
                o_done = 1'b1;
            end
        end
        @(negedge i_clk);
        o_data_oe <= 1'b0;
        o_done = 1'b1;
    end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
    import ext_ack_pkg::*;
    logic i_clk = 1'b0, i_resetn = 1'b0, go = 1'b0, rd = 1'b1, ds = 1'b1, en = 1'b1;
    logic [ADDR_W-1:0] addr = '0, m_addr, cap_addr;
    logic [1:0] m_size, cap_size;
    logic [WAIT_W-1:0] wcnt = '0;
    logic strobe_n, rw, ack_n, ack_oe, addr_oe, cap_rw, busy, data_oe, done, seen_oe;
    logic [31:0] data;
    int edges, cycles = 0, miscompares = 0, checks_done = 0;
    wire logic ack_line = ack_oe ? ack_n : 1'b1; // pulled up when released
    ext_bus_master_model ext_bus_master_model_i (.i_clk(i_clk), .i_go(go), .i_rd(rd),
        .i_addr(addr), .i_size(2'h2), .i_ack_n(ack_line), .o_strobe_n(strobe_n),
        .o_addr(m_addr), .o_rw(rw), .o_size(m_size), .o_data(data), .o_data_oe(data_oe),
        .o_done(done), .o_edges(edges));
    ext_master_auto_ack ext_master_auto_ack_i (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_cycle_begin_strobe_n(strobe_n), .i_addr(m_addr), .i_read_write(rw),
        .i_transfer_size(m_size), .i_default_space(ds), .i_master_auto_ack_enable(en),
        .i_wait_count_field(wcnt), .o_termination_ack_n(ack_n),
        .o_termination_ack_oe(ack_oe), .o_addr_oe(addr_oe), .o_cap_addr(cap_addr),
        .o_cap_read_write(cap_rw), .o_cap_transfer_size(cap_size), .o_busy(busy));
    always #2 i_clk = ~i_clk;
    // hang guard, far above the longest sequence
    always @(posedge i_clk) begin
        cycles++;
        if (ack_oe === 1'b1) seen_oe = 1'b1;
        if (cycles == 3000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        if (miscompares == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // exp is the edge at which the master sees ack, 0 when nobody acks
    task automatic xfer(input logic r, e, d, input logic [3:0] w, input logic [27:0] a,
        input int exp);
        int k;
        @(negedge i_clk);
        {rd, en, ds, wcnt, addr} = {r, e, d, w, a};
        seen_oe = 1'b0;
        go = 1'b1;
        @(negedge i_clk);
        go = 1'b0;
        for (k = 0; k < 40 && done !== 1'b1; k++) @(posedge i_clk) #1;
        check(edges, exp);
        check({cap_addr, cap_rw, cap_size, addr_oe}, {a, r, 2'h2, 1'b0});
        if (exp != 0) begin
            check({ack_n, ack_oe}, 2'b11);
            check(data_oe, !r);
            if (!r) check(data, {4'hA, a});
            @(posedge i_clk) #1;
            check(data_oe, 1'b0);
        end
        check({ack_oe, busy, seen_oe}, {2'b00, exp != 0});
    endtask
    task automatic read_no_wait(); xfer(1'b1, 1'b1, 1'b1, 4'h0, 28'h0000100, 3); endtask
    task automatic write_waits(); xfer(1'b0, 1'b1, 1'b1, 4'h3, 28'h0ABCDE4, 6); endtask
    task automatic read_max_wait(); xfer(1'b1, 1'b1, 1'b1, 4'hF, 28'hFFFFFFC, 18); endtask
    task automatic write_one_wait(); xfer(1'b0, 1'b1, 1'b1, 4'h1, 28'h0000008, 4); endtask
    task automatic read_two_wait(); xfer(1'b1, 1'b1, 1'b1, 4'h2, 28'h0000200, 5); endtask
    task automatic enable_off(); xfer(1'b1, 1'b0, 1'b1, 4'h0, 28'h0000010, 0); endtask
    task automatic other_space(); xfer(1'b0, 1'b1, 1'b0, 4'h2, 28'h1234560, 0); endtask
    // reset in mid-wait: outputs drop to idle and the master never sees an acknowledge
    task automatic reset_mid_cycle();
        @(negedge i_clk);
        {rd, en, ds, wcnt, addr} = {1'b1, 1'b1, 1'b1, 4'hF, 28'h0000040};
        go = 1'b1;
        @(negedge i_clk);
        go = 1'b0;
        repeat (4) @(negedge i_clk);
        i_resetn = 1'b0;
        @(negedge i_clk);
        i_resetn = 1'b1;
        check({busy, ack_oe, ack_n, cap_rw, cap_addr}, {4'h3, 28'h0000000});
        while (done !== 1'b1) @(negedge i_clk);
        check(edges, 0);
    endtask
    initial begin
        repeat (8) @(negedge i_clk);
        i_resetn = 1'b1;
        check({busy, ack_oe, ack_n, cap_rw}, 4'h3);
        read_no_wait();
        write_waits();
        read_max_wait();
        write_one_wait();
        read_two_wait();
        enable_off();
        other_space();
        reset_mid_cycle();
        read_no_wait();
        close_out();
    end
endmodule
`default_nettype wire
